// >>> hw/hall_sensor_conversion_sequencer.sv
// conversion sequencer of a three-axis hall sensor with its done pulse
// assumes mode and channel set are held stable by the register side;
// the external trigger comes from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_conversion_sequencer
#(
  parameter int unsigned LP_SLOW_CYCLES = hall_seq_pkg::LP_SLOW_CYC,
  parameter int unsigned LP_FAST_CYCLES = hall_seq_pkg::LP_FAST_CYC,
  parameter int unsigned CONV_CYCLES    = hall_seq_pkg::CONV_CYC
)
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [1:0]         mode,
  input  wire logic [1:0]         channelSet,
  input  wire logic               lowPowerFast,
  input  wire logic               busTrigger,
  input  wire logic               extTriggerPin,
  input  wire logic               doneEnable,
  output logic                    convDone_n,
  output logic                    updateX,
  output logic                    updateY,
  output logic                    updateZ,
  output logic                    updateTemp,
  output logic                    cycleBusy
);
  ////////////////////////////////////////////////////////////////////////
  localparam logic [9:0]  DONE_LEN = 10'(hall_seq_pkg::DONE_CYC);
  // accepted band for the low time of the done pulse, in clock cycles
  localparam logic [9:0]  DONE_LO  =
    10'((hall_seq_pkg::DONE_MIN_NS * hall_seq_pkg::CLK_MHZ) / 1000);
  localparam logic [9:0]  DONE_HI  =
    10'((hall_seq_pkg::DONE_MAX_NS * hall_seq_pkg::CLK_MHZ) / 1000);
  localparam logic [31:0] CONV_LEN = 32'(CONV_CYCLES);

  logic [2:0]  extSync_q;
  logic        extLevel_q;
  logic        extRise;
  logic [31:0] convCnt_q;
  logic [31:0] convCnt_d;
  logic [31:0] lpCnt_q;
  logic [31:0] lpCnt_d;
  logic [9:0]  doneCnt_q;
  logic [9:0]  doneCnt_d;
  logic [9:0]  doneLow_q;
  hall_seq_pkg::state_type state_q;
  hall_seq_pkg::state_type state_d;
  wire         convEnd;
  wire         lpTick;
  wire         startReq;
  wire         isFast;
  wire         lastY;
  wire         lastZ;
  wire [31:0]  lpPeriod;

  ////////////////////////////////////////////////////////////////////////
  // three-stage sampling; second and third must agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      extSync_q  <= 3'h0;
      extLevel_q <= 1'b0;
    end
    else
    begin
      extSync_q <= {extSync_q[1:0], extTriggerPin};
      if (extSync_q[1] == extSync_q[2])
        extLevel_q <= extSync_q[2];
    end
  end
  assign extRise = (extSync_q[1] == extSync_q[2]) && extSync_q[2] && !extLevel_q;

  ////////////////////////////////////////////////////////////////////////
  assign isFast   = (mode == hall_seq_pkg::MODE_FAST);
  assign lpPeriod = lowPowerFast ? 32'(LP_FAST_CYCLES) : 32'(LP_SLOW_CYCLES);
  assign lpTick   = (mode == hall_seq_pkg::MODE_LOW_POWER) && (lpCnt_q == 32'h0);
  // start sources per mode; power down never starts
  assign startReq = isFast
                 || lpTick
                 || ((mode == hall_seq_pkg::MODE_MASTER) && (busTrigger || extRise));
  assign convEnd  = (convCnt_q == CONV_LEN - 32'h1);
  assign lastY    = (channelSet == hall_seq_pkg::CHANS_XY);
  assign lastZ    = (channelSet == hall_seq_pkg::CHANS_XYZ);

  // low power update timer free-runs while in that mode
  always_comb
  begin
    lpCnt_d = lpCnt_q;
    if (mode != hall_seq_pkg::MODE_LOW_POWER || lpCnt_q == 32'h0)
      lpCnt_d = lpPeriod - 32'h1;
    else
      lpCnt_d = lpCnt_q - 32'h1;
  end

  always_comb
  begin
    state_d   = state_q;
    convCnt_d = 32'h0;
    doneCnt_d = doneCnt_q;
    unique case (state_q)
      hall_seq_pkg::ST_IDLE:
        if (startReq)
          state_d = hall_seq_pkg::ST_X;
      hall_seq_pkg::ST_X:
        if (convEnd)
          state_d = hall_seq_pkg::ST_Y;
        else
          convCnt_d = convCnt_q + 32'h1;
      hall_seq_pkg::ST_Y:
        if (convEnd)
          state_d = lastY ? hall_seq_pkg::ST_DONE : hall_seq_pkg::ST_Z;
        else
          convCnt_d = convCnt_q + 32'h1;
      hall_seq_pkg::ST_Z:
        if (convEnd)
          state_d = lastZ ? hall_seq_pkg::ST_DONE : hall_seq_pkg::ST_T;
        else
          convCnt_d = convCnt_q + 32'h1;
      hall_seq_pkg::ST_T:
        if (convEnd)
          state_d = hall_seq_pkg::ST_DONE;
        else
          convCnt_d = convCnt_q + 32'h1;
      hall_seq_pkg::ST_DONE:
        state_d = hall_seq_pkg::ST_IDLE;
      default:
        state_d = hall_seq_pkg::ST_IDLE;
    endcase
    // done pulse start at cycle end, counted down independently
    if (state_q == hall_seq_pkg::ST_DONE && doneEnable)
      doneCnt_d = DONE_LEN;
    else if (doneCnt_q != 10'h0)
      doneCnt_d = doneCnt_q - 10'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q   <= hall_seq_pkg::ST_IDLE;
      convCnt_q <= 32'h0;
      lpCnt_q   <= 32'h0;
      doneCnt_q <= 10'h0;
    end
    else
    begin
      state_q   <= state_d;
      convCnt_q <= convCnt_d;
      lpCnt_q   <= lpCnt_d;
      doneCnt_q <= doneCnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs registered; updates pulse when a channel result lands
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      convDone_n <= 1'b1;
      updateX    <= 1'b0;
      updateY    <= 1'b0;
      updateZ    <= 1'b0;
      updateTemp <= 1'b0;
      cycleBusy  <= 1'b0;
    end
    else
    begin
      convDone_n <= (doneCnt_d == 10'h0);
      updateX    <= (state_q == hall_seq_pkg::ST_X) && convEnd;
      updateY    <= (state_q == hall_seq_pkg::ST_Y) && convEnd;
      updateZ    <= (state_q == hall_seq_pkg::ST_Z) && convEnd;
      updateTemp <= (state_q == hall_seq_pkg::ST_T) && convEnd;
      cycleBusy  <= (state_d != hall_seq_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low-time counter, used by the width check only; a retriggered pulse shows as too long
  always_ff @(posedge sys_clk)
  begin
    if (rst || convDone_n)
      doneLow_q <= 10'h0;
    else
      doneLow_q <= doneLow_q + 10'h1;
  end

  chk_done_width: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(convDone_n) |-> (doneLow_q >= DONE_LO) && (doneLow_q <= DONE_HI))
    else $error("done pulse width wrong");
  chk_done_source: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(convDone_n) |-> ($past(state_q) == hall_seq_pkg::ST_DONE) && $past(doneEnable))
    else $error("done pulse without cycle end");
  chk_fast_restart: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_DONE && isFast) |=> ##1 (state_q == hall_seq_pkg::ST_X))
    else $error("fast mode did not restart");
  chk_trigger_only: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_IDLE && !isFast && !lpTick && !busTrigger && !extRise)
      |=> (state_q == hall_seq_pkg::ST_IDLE))
    else $error("cycle started without trigger");
  chk_xyzt_end: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_DONE && channelSet == hall_seq_pkg::CHANS_XYZT)
      |-> $past(state_q) == hall_seq_pkg::ST_T)
    else $error("four-channel cycle ended early");
  chk_no_temp: assert property (@(posedge sys_clk) disable iff (rst)
    ((channelSet == hall_seq_pkg::CHANS_XYZ || channelSet == hall_seq_pkg::CHANS_XY)
      && $stable(channelSet)) |-> !updateTemp)
    else $error("temperature updated while disabled");
  chk_planar_noz: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_Y && convEnd && lastY) |=> state_q == hall_seq_pkg::ST_DONE)
    else $error("planar cycle went past y");
  chk_master_start: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_IDLE && mode == hall_seq_pkg::MODE_MASTER && busTrigger)
      |=> state_q == hall_seq_pkg::ST_X)
    else $error("bus trigger ignored");
  chk_order_xy: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == hall_seq_pkg::ST_X && convEnd)
      |=> (state_q == hall_seq_pkg::ST_Y && updateX) ##1 !updateX)
    else $error("channel order broken");
endmodule
`default_nettype wire

// >>> hw/hall_seq_pkg.sv
// constants for the hall sensor conversion sequencer
// assumes a 100 MHz system clock
package hall_seq_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // pulse on the conversion-done pin, ns
  localparam int unsigned DONE_MIN_NS = 1800;
  localparam int unsigned DONE_MAX_NS = 3200;
  localparam int unsigned DONE_NS = 2500;
  localparam int unsigned DONE_CYC = (DONE_NS * CLK_MHZ) / 1000;
  // master read windows, us, kept for the bench
  localparam int unsigned FIRST_READ_MIN_US = 30;
  localparam int unsigned FIRST_READ_MAX_US = 50;
  localparam int unsigned NEXT_READ_MIN_US = 32;
  localparam int unsigned NEXT_READ_MAX_US = 54;
  localparam int unsigned SR_FIRST_READ_MIN_US = 42;
  localparam int unsigned SR_FIRST_READ_MAX_US = 70;
  localparam int unsigned SR_NEXT_READ_MIN_US = 44;
  localparam int unsigned SR_NEXT_READ_MAX_US = 74;
  localparam int unsigned FAST_BUS_MIN_KHZ = 800;
  // per-channel conversion time, cycles
  localparam int unsigned CONV_CYC = 1000;
  // low power periods: 10 Hz and 160 Hz
  localparam int unsigned LP_SLOW_HZ = 10;
  localparam int unsigned LP_FAST_HZ = 160;
  localparam int unsigned LP_SLOW_CYC = CLK_MHZ * 1000000 / LP_SLOW_HZ;
  localparam int unsigned LP_FAST_CYC = CLK_MHZ * 1000000 / LP_FAST_HZ;
  // operating modes
  typedef enum logic [1:0] {
    MODE_POWER_DOWN = 2'h0,
    MODE_MASTER     = 2'h1,
    MODE_LOW_POWER  = 2'h2,
    MODE_FAST       = 2'h3
  } mode_type;
  // channel sets
  typedef enum logic [1:0] {
    CHANS_XYZT = 2'h0,
    CHANS_XYZ  = 2'h1,
    CHANS_XY   = 2'h2
  } chans_type;
  // sequencer states, gray along the conversion path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_X    = 3'h1,
    ST_Y    = 3'h3,
    ST_Z    = 3'h2,
    ST_T    = 3'h6,
    ST_DONE = 3'h7
  } state_type;
endpackage

// >>> verification/hall_master_model.sv
// bus master model: fires the trigger pin and paces reads off the done pulse
// assumes convDone_n is the sequencer's low-active done pin
`timescale 1ns/1ps
`default_nettype none
module hall_master_model
(
  input  wire logic convDone_n,
  input  wire logic fireExt,
  input  wire logic slowReads,
  input  wire logic shortRange,
  output logic      extTriggerPin,
  output logic      readPulse
);
  ////////////////////////////////////////////////////////////
  int unsigned firstUs;
  int unsigned nextUs;
  initial extTriggerPin = 1'b0;
  initial readPulse = 1'b0;
  // pin held for one link period
  always @(posedge fireExt)
  begin
    extTriggerPin = 1'b1;
    #125 extTriggerPin = 1'b0;
  end
  // reads paced by the done pulse at a fast bus rate, early or late end of each window
  always @(posedge convDone_n)
  begin
    if (shortRange)
    begin
      firstUs = slowReads ? hall_seq_pkg::SR_FIRST_READ_MAX_US
                          : hall_seq_pkg::SR_FIRST_READ_MIN_US;
      nextUs  = slowReads ? hall_seq_pkg::SR_NEXT_READ_MAX_US
                          : hall_seq_pkg::SR_NEXT_READ_MIN_US;
    end
    else
    begin
      firstUs = slowReads ? hall_seq_pkg::FIRST_READ_MAX_US
                          : hall_seq_pkg::FIRST_READ_MIN_US;
      nextUs  = slowReads ? hall_seq_pkg::NEXT_READ_MAX_US
                          : hall_seq_pkg::NEXT_READ_MIN_US;
    end
    #(firstUs * 1000);
    readPulse = 1'b1;
    #1000 readPulse = 1'b0;
    #(nextUs * 1000 - 1000);
    readPulse = 1'b1;
    #1000 readPulse = 1'b0;
  end
endmodule
`default_nettype wire

// >>> verification/hall_sensor_conversion_sequencer_tb.sv
// testbench for the hall conversion sequencer
// assumes short conversion and low power counts set below
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_conversion_sequencer_tb;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [1:0] channelSet = 2'h0;
  logic       lowPowerFast = 1'b0;
  logic       busTrigger = 1'b0;
  logic       doneEnable = 1'b1;
  logic       fireExt = 1'b0;
  logic       slowReads = 1'b0;
  logic       shortRange = 1'b0;
  wire logic  extTriggerPin;
  wire logic  convDone_n, updateX, updateY, updateZ, updateTemp, cycleBusy;
  int         n_fail = 0;
  int         check_count = 0;
  int         seq = 0;
  int         lowLen = 0;
  int         lastLow = 0;
  int         dones = 0;
  int         cyc = 0;
  ////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  // every cycle outlasts the done pulse, so pulses never merge in fast mode
  hall_sensor_conversion_sequencer #(.LP_SLOW_CYCLES(2000), .LP_FAST_CYCLES(1000),
    .CONV_CYCLES(150)) DUT (.sys_clk(sys_clk), .rst(rst), .mode(mode),
    .channelSet(channelSet), .lowPowerFast(lowPowerFast), .busTrigger(busTrigger),
    .extTriggerPin(extTriggerPin), .doneEnable(doneEnable), .convDone_n(convDone_n),
    .updateX(updateX), .updateY(updateY), .updateZ(updateZ), .updateTemp(updateTemp),
    .cycleBusy(cycleBusy));
  hall_master_model partner (.convDone_n(convDone_n), .fireExt(fireExt),
    .slowReads(slowReads), .shortRange(shortRange), .extTriggerPin(extTriggerPin),
    .readPulse());
  ////////////////////////////////////////////////////////////
  // channel order kept as decimal digits, done width in cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (updateX === 1'b1) seq = seq * 10 + 1;
    if (updateY === 1'b1) seq = seq * 10 + 2;
    if (updateZ === 1'b1) seq = seq * 10 + 3;
    if (updateTemp === 1'b1) seq = seq * 10 + 4;
    if (convDone_n === 1'b0) lowLen++;
    else if (lowLen != 0)
    begin
      lastLow = lowLen;
      lowLen = 0;
      dones++;
    end
    if (cyc == 40000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic bus_start();
    busTrigger = 1'b1;
    tick(1);
    busTrigger = 1'b0;
  endtask
  task automatic t_sets();
    int exp [3] = '{1234, 123, 12};
    int d0;
    for (int i = 0; i < 3; i++)
    begin
      channelSet = 2'(i);
      seq = 0;
      d0 = dones;
      bus_start();
      tick(100);
      check(32'(cycleBusy), 32'h1);
      // a second trigger in mid-cycle must be ignored
      bus_start();
      tick(800);
      check(seq, exp[i]);
      check(dones - d0, 32'h1);
      check(32'(lastLow >= 180 && lastLow <= 320), 32'h1);
    end
    $display("test channel sets done");
  endtask
  task automatic t_no_start();
    int d0;
    d0 = dones;
    tick(300);
    check(32'(cycleBusy), 32'h0);
    doneEnable = 1'b0;
    seq = 0;
    fireExt = 1'b1;
    tick(900);
    fireExt = 1'b0;
    check(seq, 32'd1234);
    check(dones, d0);
    doneEnable = 1'b1;
    mode = hall_seq_pkg::MODE_POWER_DOWN;
    seq = 0;
    bus_start();
    tick(900);
    check(dones, d0);
    check(seq, 32'h0);
    $display("test trigger and refusal done");
  endtask
  task automatic t_free(input logic [1:0] m, input logic f, input int lo, input int hi);
    int d0;
    // rate is set a cycle early so the update timer loads the new period
    lowPowerFast = f;
    tick(1);
    mode = m;
    d0 = dones;
    tick(5000);
    check(32'(dones - d0 >= lo && dones - d0 <= hi), 32'h1);
    mode = hall_seq_pkg::MODE_MASTER;
    tick(900);
    $display("test free running mode %0d done", m);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    tick(12);
    rst = 1'b0;
    mode = hall_seq_pkg::MODE_MASTER;
    t_sets();
    channelSet = 2'h0;
    t_no_start();
    slowReads = 1'b1;
    shortRange = 1'b1;
    t_free(hall_seq_pkg::MODE_FAST, 1'b0, 6, 8);
    t_free(hall_seq_pkg::MODE_LOW_POWER, 1'b1, 4, 5);
    t_free(hall_seq_pkg::MODE_LOW_POWER, 1'b0, 2, 3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
